// >>> src/ext_data_access_pkg.sv
// types for the external data move sequencer
`default_nettype none
package ext_data_access_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_FETCH  = 3'b001,
        ST_ADDR   = 3'b010,
        ST_STROBE = 3'b011,
        ST_TAIL   = 3'b100
    } seq_state_t;
endpackage
`default_nettype wire

// >>> src/ext_data_access_stretch.sv
// sequencer for the fetch and stretched access cycles of an external data move
`default_nettype none
`include "ext_data_access_stretch_regs.svh"
// Functional notes
// - every external data move starts with a four clock opcode fetch
// - the cycle after the fetch drives the address and performs the access
// - stretch comes from bits 2..0 of the clock control register
// - stretch 0..7 gives instructions of 2..9 machine cycles
// - only external data moves are lengthened; cpu is held meanwhile
// - stretch resets to one, giving three machine cycles
// - strobe width is 2 clocks at zero, else 4 clocks per step
// - wait input only honoured when wait enable is set
// - wait sampled at the last clock state before strobe rise; adds a cycle
// - wait cycles are unlimited; access ends when wait is released
module ext_data_access_stretch
    import ext_data_access_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        start_i,
    input  wire logic        write_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        clock_control_reg_we_i,
    input  wire logic [7:0]  clock_control_reg_wdata_i,
    input  wire logic        wait_enable_i,
    input  wire logic        wait_i,
    input  wire logic [7:0]  data_i,
    output logic      [2:0]  stretch_select_o,
    output logic             cpu_hold_o,
    output logic             busy_o,
    output logic             done_o,
    output logic      [7:0]  rdata_o,
    output logic      [15:0] addr_o,
    output logic      [7:0]  data_o,
    output logic             data_oe_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o
);
    seq_state_t  state, next_state;
    logic [2:0]  stretch_select, next_stretch_select;
    logic [2:0]  lat_stretch, next_lat_stretch;
    logic [4:0]  cnt, next_cnt;
    logic        is_wr, next_is_wr;
    logic [15:0] addr_q, next_addr_q;
    logic [7:0]  wdat, next_wdat;
    logic [7:0]  rdat, next_rdat;
    logic        done, next_done;
    logic        rd_n, next_rd_n;
    logic        wr_n, next_wr_n;
    logic        oe_n, next_oe_n;
    logic [4:0]  strobe_clocks;
    logic [3:0]  mach_cycles;

    strobe_width_calc u_calc (
        .stretch_i       (lat_stretch),
        .strobe_clocks_o (strobe_clocks),
        .mach_cycles_o   (mach_cycles)
    );

    // tail count so that fetch, setup, strobe and tail fill exactly 4*mc clocks
    function automatic logic [4:0] tail_clocks(input logic [3:0] mc, input logic [4:0] sw);
        tail_clocks = 5'({mc, 2'b00} - {1'b0, sw} - 6'h06);
    endfunction

    // the shared down counter has run out
    function automatic logic count_out(input logic [4:0] c);
        count_out = (c == 5'h00);
    endfunction

    // a wait pin left floating high must not stretch moves unless enabled
    logic wait_req;
    always_comb
    begin
        wait_req = wait_enable_i && wait_i;
    end

    always_comb
    begin
        next_stretch_select = stretch_select;
        if (clock_control_reg_we_i)
            next_stretch_select = clock_control_reg_wdata_i[`STRETCH_MSB:`STRETCH_LSB];
        next_state       = state;
        next_lat_stretch = lat_stretch;
        next_cnt         = cnt;
        next_is_wr       = is_wr;
        next_addr_q      = addr_q;
        next_wdat        = wdat;
        next_rdat        = rdat;
        next_done        = 1'b0;
        next_rd_n        = 1'b1;
        next_wr_n        = 1'b1;
        next_oe_n        = 1'b1;
        case (state)
            ST_IDLE:
            begin
                if (start_i)
                begin
                    // latched once: later writes cannot disturb this access
                    next_lat_stretch = stretch_select;
                    next_is_wr       = write_i;
                    next_addr_q      = addr_i;
                    next_wdat        = wdata_i;
                    next_cnt         = 5'(`FETCH_CLOCKS) - 5'h1;
                    next_state       = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                if (count_out(cnt))
                    next_state = ST_ADDR;
                else
                    next_cnt = cnt - 5'h1;
            end
            ST_ADDR:
            begin
                // one clock of address setup, then strobe
                next_oe_n  = ~is_wr;
                next_cnt   = strobe_clocks - 5'h1;
                next_rd_n  = is_wr;
                next_wr_n  = ~is_wr;
                next_state = ST_STROBE;
            end
            ST_STROBE:
            begin
                next_oe_n  = ~is_wr;
                next_rd_n  = is_wr;
                next_wr_n  = ~is_wr;
                if (count_out(cnt))
                begin
                    // last clock state before strobe rise: extend per cycle
                    if (wait_req)
                        next_cnt = 5'h3;
                    else
                    begin
                        next_rdat  = data_i;
                        next_rd_n  = 1'b1;
                        next_wr_n  = 1'b1;
                        next_cnt   = tail_clocks(mach_cycles, strobe_clocks);
                        next_state = ST_TAIL;
                    end
                end
                else
                    next_cnt = cnt - 5'h1;
            end
            ST_TAIL:
            begin
                next_oe_n = 1'b1;
                // bit 4 only guards a wrapped count so the sequencer cannot hang
                if (count_out(cnt) || cnt[4])
                begin
                    next_done  = 1'b1;
                    next_state = ST_IDLE;
                end
                else
                    next_cnt = cnt - 5'h1;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state          <= ST_IDLE;
            stretch_select <= `STRETCH_RESET;
            lat_stretch    <= `STRETCH_RESET;
            cnt            <= 5'h00;
            is_wr          <= 1'b0;
            addr_q         <= 16'h0000;
            wdat           <= 8'h00;
            rdat           <= 8'h00;
            done           <= 1'b0;
            rd_n           <= 1'b1;
            wr_n           <= 1'b1;
            oe_n           <= 1'b1;
        end
        else
        begin
            state          <= next_state;
            stretch_select <= next_stretch_select;
            lat_stretch    <= next_lat_stretch;
            cnt            <= next_cnt;
            is_wr          <= next_is_wr;
            addr_q         <= next_addr_q;
            wdat           <= next_wdat;
            rdat           <= next_rdat;
            done           <= next_done;
            rd_n           <= next_rd_n;
            wr_n           <= next_wr_n;
            oe_n           <= next_oe_n;
        end
    end

    // hold only while a move is under way; other instructions never see it
    logic hold_q, next_hold;
    always_comb
    begin
        next_hold = (next_state != ST_IDLE);
    end
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            hold_q <= 1'b0;
        else
            hold_q <= next_hold;
    end

    assign stretch_select_o = stretch_select;
    assign cpu_hold_o       = hold_q;
    assign busy_o           = hold_q;
    assign done_o           = done;
    assign rdata_o          = rdat;
    assign addr_o           = addr_q;
    assign data_o           = wdat;
    assign data_oe_n_o      = oe_n;
    assign rd_n_o           = rd_n;
    assign wr_n_o           = wr_n;
endmodule
`default_nettype wire

// >>> src/ext_data_access_stretch_regs.svh
// timing constants and field layout for the external data move sequencer
`ifndef EXT_DATA_ACCESS_STRETCH_REGS_SVH
`define EXT_DATA_ACCESS_STRETCH_REGS_SVH

`define CLOCKS_PER_MC       3'h4
`define STRETCH_MSB         2
`define STRETCH_LSB         0
`define STRETCH_RESET       3'h1
`define FETCH_CLOCKS        3'h4
`define STROBE_MIN_CLOCKS   5'h02
`define STROBE_STEP_CLOCKS  5'h04

`endif

// >>> src/strobe_width_calc.sv
// strobe width and machine cycle count derived from the stretch setting
`default_nettype none
`include "ext_data_access_stretch_regs.svh"
module strobe_width_calc
    import ext_data_access_pkg::*;
(
    input  wire logic [2:0] stretch_i,
    output logic      [4:0] strobe_clocks_o,
    output logic      [3:0] mach_cycles_o
);
    function automatic logic [4:0] strobe_width(input logic [2:0] s);
        // 2 clocks at zero, then 4 per step
        if (s == 3'h0)
            strobe_width = `STROBE_MIN_CLOCKS;
        else
            strobe_width = 5'({s, 2'b00});
    endfunction

    always_comb
    begin
        strobe_clocks_o = strobe_width(stretch_i);
        mach_cycles_o   = 4'({1'b0, stretch_i}) + 4'h2;
    end
endmodule
`default_nettype wire

// >>> verification/ext_data_access_stretch_properties.sv
// port checker for the external data move sequencer
`default_nettype none
module ext_data_access_stretch_properties (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        start_i,
    input wire logic        clock_control_reg_we_i,
    input wire logic [7:0]  clock_control_reg_wdata_i,
    input wire logic [2:0]  stretch_select_o,
    input wire logic        cpu_hold_o,
    input wire logic        busy_o,
    input wire logic [15:0] addr_o,
    input wire logic        data_oe_n_o,
    input wire logic        rd_n_o,
    input wire logic        wr_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_take; start_i && !busy_o; endsequence
    sequence s_quiet; busy_o && rd_n_o && wr_n_o; endsequence
    property p_load;
        logic [2:0] v;
        (clock_control_reg_we_i, v = clock_control_reg_wdata_i[2:0]) |=> stretch_select_o == v;
    endproperty
    a_fetch_then_addr: assert property (s_take |=> s_quiet[*5])
        else $error("strobe during fetch");
    a_strobe_held: assert property (!rd_n_o || !wr_n_o |-> busy_o && cpu_hold_o)
        else $error("strobe outside move");
    a_write_drives: assert property (!wr_n_o |-> !data_oe_n_o && rd_n_o)
        else $error("write not driving");
    a_read_floats: assert property (!rd_n_o |-> data_oe_n_o)
        else $error("read driving bus");
    a_addr_steady: assert property (!rd_n_o || !wr_n_o |-> $stable(addr_o))
        else $error("address moved");
    a_stretch_load: assert property (p_load)
        else $error("stretch not loaded");
    a_reset_one: assert property ($rose(rstn_i) |-> stretch_select_o == 3'h1)
        else $error("stretch reset wrong");
    a_strobe_min: assert property ($fell(rd_n_o) |=> !rd_n_o)
        else $error("strobe too short");
endmodule
bind ext_data_access_stretch ext_data_access_stretch_properties i_props (.clk_i, .rstn_i,
    .start_i, .clock_control_reg_we_i, .clock_control_reg_wdata_i, .stretch_select_o, .cpu_hold_o, .busy_o,
    .addr_o, .data_oe_n_o, .rd_n_o, .wr_n_o);
`default_nettype wire

// >>> verification/ext_data_access_stretch_tb.sv
// self-checking bench for the external data move sequencer
`default_nettype none
module ext_data_access_stretch_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rstn_i = 0, start_i = 0, write_i = 0, clock_control_reg_we_i = 0;
    logic wait_enable_i = 0, cpu_hold_o, busy_o, done_o, data_oe_n_o, rd_n_o, wr_n_o;
    logic wait_i;
    logic [15:0] addr_i = 16'h0000, addr_o;
    logic [7:0] wdata_i = 8'h00, clock_control_reg_wdata_i = 8'h00, data_i, rdata_o, data_o, written;
    logic [7:0] hold_len = 8'h00;
    logic [2:0] stretch_select_o;
    int bad_count = 0, checks = 0, cyc = 0;
    always #50 clk_i = ~clk_i;
    ext_data_access_stretch i_dut (.clk_i, .rstn_i, .start_i, .write_i, .addr_i, .wdata_i,
        .clock_control_reg_we_i, .clock_control_reg_wdata_i, .wait_enable_i, .wait_i, .data_i, .stretch_select_o,
        .cpu_hold_o, .busy_o, .done_o, .rdata_o, .addr_o, .data_o, .data_oe_n_o, .rd_n_o,
        .wr_n_o);
    ext_mem_model i_mem (.clk_i, .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .oe_n_i(data_oe_n_o),
        .addr_i(addr_o), .wdata_i(data_o), .hold_len_i(hold_len), .rdata_o(data_i),
        .wait_o(wait_i), .written_o(written));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic set_stretch(input logic [2:0] s);
        @(posedge clk_i) clock_control_reg_we_i <= 1'b1;
        clock_control_reg_wdata_i <= {5'h18, s};
        @(posedge clk_i) clock_control_reg_we_i <= 1'b0;
        // let the register settle before anyone looks at it
        #1;
    endtask
    // one whole move; n wait samples are requested, honoured only with wen
    task automatic move(input logic wr, input logic [2:0] s, input logic wen, input int n);
        int t, w, h, sw;
        t = 0;
        w = 0;
        h = 0;
        sw = (s == 3'h0) ? 2 : 4 * s;
        @(posedge clk_i) start_i <= 1'b1;
        write_i <= wr;
        addr_i <= 16'h4A00 + 16'(s);
        wdata_i <= 8'h90 + 8'(s);
        wait_enable_i <= wen;
        hold_len <= (n == 0) ? 8'h00 : 8'(sw + 4 * (n - 1));
        @(posedge clk_i) start_i <= 1'b0;
        #1;
        while (done_o !== 1'b1 && t < 400)
        begin
            w += int'(rd_n_o === 1'b0 || wr_n_o === 1'b0);
            h += int'(cpu_hold_o === 1'b1);
            @(posedge clk_i) #1 t++;
        end
        if (!wen)
            n = 0;
        check("strobe width", w, sw + 4 * n);
        check("move length", t, 4 * (s + 2) + 4 * n);
        check("cpu hold", h, 4 * (s + 2) + 4 * n);
        check("address", addr_o, 16'h4A00 + s);
        check("data", wr ? written : rdata_o, wr ? 8'h90 + s : 8'hA5 ^ s);
    endtask
    task automatic t_reset();
        check("stretch", stretch_select_o, 3'h1);
        check("strobes", {rd_n_o, wr_n_o, data_oe_n_o, busy_o}, 4'hE);
        move(1'b0, 3'h1, 1'b0, 0);
    endtask
    task automatic t_sweep();
        for (int s = 0; s < 8; s++)
        begin
            set_stretch(3'(s));
            check("stretch", stretch_select_o, s);
            move(1'b0, 3'(s), 1'b0, 0);
            move(1'b1, 3'(s), 1'b0, 0);
        end
    endtask
    task automatic t_wait();
        set_stretch(3'h1);
        move(1'b0, 3'h1, 1'b1, 3);
        move(1'b1, 3'h2 - 3'h1, 1'b1, 1);
        move(1'b0, 3'h1, 1'b0, 3);
    endtask
    task automatic t_midrun();
        set_stretch(3'h2);
        fork
            move(1'b0, 3'h2, 1'b0, 0);
            begin
                repeat (8) @(posedge clk_i);
                set_stretch(3'h5);
            end
        join
        check("stretch", stretch_select_o, 3'h5);
        move(1'b1, 3'h5, 1'b0, 0);
    endtask
    // a second reset must bring a changed stretch back to one
    task automatic t_reset_again();
        @(posedge clk_i) rstn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        check("stretch", stretch_select_o, 3'h1);
        check("strobes", {rd_n_o, wr_n_o, data_oe_n_o, busy_o}, 4'hE);
        move(1'b1, 3'h1, 1'b0, 0);
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        t_reset();
        t_sweep();
        t_wait();
        t_midrun();
        t_reset_again();
        stop_test();
    end
endmodule
`default_nettype wire

// >>> verification/ext_mem_model.sv
// behavioural external data memory that can request wait cycles
`default_nettype none
module ext_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic [7:0]  hold_len_i,
    output logic      [7:0]  rdata_o,
    output logic             wait_o,
    output logic      [7:0]  written_o
);
    logic [7:0] low_cnt = 8'h00;
    logic [7:0] last    = 8'h00;
    // a released bus toggles so a stale byte cannot pass as read data
    assign rdata_o = !rd_n_i ? addr_i[7:0] ^ 8'hA5 : ~last;
    // wait held for hold_len strobe clocks, so it is seen at hold samples
    assign wait_o = (!rd_n_i || !wr_n_i) && (low_cnt < hold_len_i);
    always_ff @(posedge clk_i)
    begin
        last <= rdata_o;
        low_cnt <= (rd_n_i && wr_n_i) ? 8'h00 : low_cnt + 8'h01;
        if (!wr_n_i && !oe_n_i)
            written_o <= wdata_i;
    end
endmodule
`default_nettype wire
